// file: src/host_register_access_port.sv
// Functional notes
// R1: Address is A12 plus A8..A0; A11..A9 zero.
// R2: Data bus undriven while chip select high.
// R3: Accesses only count with chip select low.
// R4: Read strobe and select low drive register.
// R5: Write strobe rising edge stores data lines.
// R6: Style pin picks strobe pair or strobe/direction.
// R7: Port select: 0 parallel, 1 serial.
// R8: Serial clock D2, data in D1, out D0.
// R9: D7 clock polarity, D6 clock phase.
// R10: D5 picks LSB-first or MSB-first order.
// R11: Interrupt low on unmasked event until acknowledged; here masking the source or the global mask also releases it.
// R12: Device reset pin clears whole port state.
// R13: Serial access: two control bytes, data byte.
// R14: Read/write bit first, burst bit last.
// R15: Select high ends burst; next byte control.
// R16: Serial out driven only in read data.
`default_nettype none
module host_register_access_port (
  input  wire logic                                clk,
  input  wire logic                                reset,
  input  wire logic                                device_reset_n,
  input  wire logic                                port_select,
  input  wire logic                                bus_style_select,
  input  wire logic                                host_select_n,
  input  wire logic                                read_strobe_n,
  input  wire logic                                write_strobe_n,
  input  wire logic                                addr_hi,
  input  wire logic [host_port_pkg::ADDR_LO_W-1:0] addr_lo,
  input  wire logic [host_port_pkg::DATA_W-1:0]    data_in,
  output var  logic [host_port_pkg::DATA_W-1:0]    data_out,
  output var  logic [host_port_pkg::DATA_W-1:0]    data_oe,
  input  wire logic [host_port_pkg::IRQ_SRC-1:0]   irq_event,
  input  wire logic [host_port_pkg::IRQ_SRC-1:0]   irq_mask,
  input  wire logic                                irq_global_mask,
  input  wire logic [host_port_pkg::IRQ_SRC-1:0]   irq_ack,
  output var  logic                                irq_out_n,
  output var  logic                                irq_oe
);
  import host_port_pkg::*;

  // ---------------------------------------------------------------
  // State, storage and decode
  // ---------------------------------------------------------------
  state_t              st;
  state_t              n;
  logic [DATA_W-1:0]   mem [MEM_DEPTH];
  logic [SYNC_W-1:0]   pins;
  logic                mem_we;
  logic [IDX_W-1:0]    mem_addr;
  logic [DATA_W-1:0]   mem_wdata;
  logic [DATA_W-1:0]   mem_rdata;
  logic [IDX_W-1:0]    rd_addr;
  logic [IDX_W-1:0]    par_idx;
  logic [IDX_W-1:0]    wr_idx;
  logic                dev_rst;
  logic                cs;
  logic                spi;
  logic                style;
  logic                rd_lvl;
  logic                wr_edge;
  logic                sclk_rise;
  logic                sclk_fall;
  logic                lead;
  logic                trail;
  logic                sample;
  logic                shift;
  logic                mosi;
  logic                swap;
  logic [13:0]         afield;
  logic [DATA_W-1:0]   wbyte;
  logic [DATA_W-1:0]   tbyte;
  logic [13:0]         afield_rev;
  logic [DATA_W-1:0]   wbyte_rev;
  logic [DATA_W-1:0]   tbyte_rev;

  assign pins = {device_reset_n, port_select, bus_style_select,
                 host_select_n, read_strobe_n, write_strobe_n,
                 addr_hi, addr_lo, data_in};

  assign dev_rst = !st.s2[RST_BIT];
  assign cs      = !st.s2[CS_BIT];
  assign spi     = st.s2[SEL_BIT];
  assign style   = st.s2[STYLE_BIT];

  // Parallel address index: A12 on top, A8..A0 below  [R1]
  assign par_idx = {st.s2[ADDR_HI_BIT], st.s2[ADDR_LSB +: ADDR_LO_W]};
  assign wr_idx  = {st.s3[ADDR_HI_BIT], st.s3[ADDR_LSB +: ADDR_LO_W]};
  assign rd_addr = spi ? st.addr : par_idx;
  assign mem_rdata = mem[rd_addr];

  // Strobe meaning chosen by style pin  [R6]
  assign rd_lvl  = style ? (!st.s2[RD_BIT] && st.s2[WR_BIT])
                         : !st.s2[RD_BIT];
  assign wr_edge = style ? (st.s2[RD_BIT] && !st.s3[RD_BIT]
                            && !st.s3[WR_BIT])
                         : (st.s2[WR_BIT] && !st.s3[WR_BIT]);

  // Serial clock edges, polarity and phase  [R8] [R9]
  assign sclk_rise = st.s2[SCLK_BIT] && !st.s3[SCLK_BIT];
  assign sclk_fall = !st.s2[SCLK_BIT] && st.s3[SCLK_BIT];
  assign lead      = st.s2[CPOL_BIT] ? sclk_fall : sclk_rise;
  assign trail     = st.s2[CPOL_BIT] ? sclk_rise : sclk_fall;
  assign sample    = st.s2[CPHA_BIT] ? trail : lead;
  assign shift     = st.s2[CPHA_BIT] ? lead : trail;
  assign mosi      = st.s2[MOSI_BIT];
  assign swap      = st.s2[SWAP_BIT];

  // Bit order of address and data fields  [R10]
  assign afield_rev = {<<{st.shreg[13:0]}};
  assign wbyte_rev  = {<<{{st.shreg[6:0], mosi}}};
  assign tbyte_rev  = {<<{mem_rdata}};
  assign afield = swap ? st.shreg[13:0] : afield_rev;
  assign wbyte  = swap ? {st.shreg[6:0], mosi} : wbyte_rev;
  assign tbyte  = swap ? mem_rdata : tbyte_rev;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    n = st;
    mem_we = 1'b0;
    mem_addr = st.addr;
    mem_wdata = st.s3[DATA_LSB +: DATA_W];
    n.s1 = pins;
    n.s2 = st.s1;
    n.s3 = st.s2;
    n.pend = (st.pend & ~irq_ack) | irq_event;            // [R11]
    n.irq = (|(n.pend & ~irq_mask)) && !irq_global_mask;  // [R11]
    n.irq_n = !n.irq;
    n.doe = OE_NONE;
    if (!spi)                                             // [R7]
    begin
      n.phase = PH_CTRL_HI;
      n.cnt = 3'h0;
      n.burst = 1'b0;
      n.rd_op = 1'b0;
      if (cs && wr_edge)                                  // [R3] [R5]
      begin
        mem_we = 1'b1;
        mem_addr = wr_idx;
      end
      if (cs && rd_lvl)                                   // [R2] [R4]
      begin
        n.doe = OE_ALL;
        n.dout = mem_rdata;
      end
    end
    else if (!cs)                                         // [R15]
    begin
      n.phase = PH_CTRL_HI;
      n.cnt = 3'h0;
      n.burst = 1'b0;
      n.rd_op = 1'b0;
    end
    else
    begin
      if (sample)
      begin
        n.shreg = {st.shreg[14:0], mosi};
        n.cnt = st.cnt + 3'h1;
        if (st.cnt == CNT_LAST)
          case (st.phase)
            PH_CTRL_HI:
              n.phase = PH_CTRL_LO;                       // [R13]
            PH_CTRL_LO:
            begin
              n.rd_op = st.shreg[14];                     // [R14]
              n.burst = mosi;                             // [R14]
              n.addr = {afield[12], afield[8:0]};         // [R1] [R10]
              n.phase = PH_DATA;                          // [R13]
            end
            default:
            begin
              if (!st.rd_op)
              begin
                mem_we = 1'b1;                            // [R5]
                mem_addr = st.addr;
                mem_wdata = wbyte;                        // [R10]
              end
              if (st.burst)
                n.addr = st.addr + 10'h001;
              else
                n.phase = PH_CTRL_HI;                     // [R13]
            end
          endcase
      end
      if (shift && st.phase == PH_DATA && st.rd_op)       // [R8]
        n.tx = (st.cnt == 3'h0) ? tbyte : {st.tx[6:0], 1'b0};
      n.doe = {7'h00, n.phase == PH_DATA && n.rd_op};     // [R16]
      n.dout = {7'h00, n.tx[7]};                          // [R8]
    end
    if (dev_rst)                                          // [R12]
    begin
      n = ST_RESET;
      n.s1 = pins;
      n.s2 = st.s1;
      n.s3 = st.s2;
      mem_we = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      st <= ST_RESET;
    else
      st <= n;
  end

  always_ff @(posedge clk)
  begin
    if (reset || dev_rst)                                 // [R12]
      for (int i = 0; i < MEM_DEPTH; i++)
        mem[i] <= MEM_RESET;
    else if (mem_we)
      mem[mem_addr] <= mem_wdata;
  end

  assign data_out  = st.dout;
  assign data_oe   = st.doe;
  assign irq_out_n = st.irq_n;
  assign irq_oe    = st.irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_par_write;
    !spi && cs && wr_edge && !dev_rst;
  endsequence

  sequence s_par_read;
    !spi && cs && rd_lvl && !dev_rst;
  endsequence

  property p_float;
    !cs |=> data_oe == OE_NONE;
  endproperty
  a_float: assert property (p_float) // [R2] [R16]
    else $error("data bus driven with select high");

  property p_read;
    s_par_read |=> data_oe == OE_ALL && data_out == $past(mem_rdata);
  endproperty
  a_read: assert property (p_read) // [R4]
    else $error("parallel read did not drive register value");

  property p_write;
    s_par_write |-> mem_we && mem_addr == wr_idx
                    && mem_wdata == st.s3[DATA_LSB +: DATA_W];
  endproperty
  a_write: assert property (p_write) // [R5]
    else $error("write edge did not store data");

  property p_no_cs;
    !cs |-> !mem_we;
  endproperty
  a_no_cs: assert property (p_no_cs) // [R3]
    else $error("write taken with select high");

  property p_style;
    !spi && style && st.s3[WR_BIT] |-> !mem_we;
  endproperty
  a_style: assert property (p_style) // [R6]
    else $error("write taken with direction set to read");

  property p_spi_pins;
    spi |=> data_oe[7:1] == 7'h00;
  endproperty
  a_spi_pins: assert property (p_spi_pins) // [R7] [R8]
    else $error("serial mode drove a parallel data line");

  property p_end;
    spi && !cs |=> st.phase == PH_CTRL_HI && st.cnt == 3'h0
                   && !st.burst;
  endproperty
  a_end: assert property (p_end) // [R15]
    else $error("select high did not end serial access");

  property p_irq_set;
    ((irq_event & ~irq_mask) != 4'h0) && !irq_global_mask
      && !dev_rst |=> irq_oe && !irq_out_n;
  endproperty
  a_irq_set: assert property (p_irq_set) // [R11]
    else $error("unmasked event did not assert interrupt");

  property p_irq_release;
    st.pend == 4'h0 |-> !irq_oe && irq_out_n;
  endproperty
  a_irq_release: assert property (p_irq_release) // [R11]
    else $error("interrupt held with nothing pending");

  property p_miso;
    $rose(data_oe[0]) && $past(spi) |-> st.phase == PH_DATA && st.rd_op;
  endproperty
  a_miso: assert property (p_miso) // [R16]
    else $error("serial output driven outside read data");

  property p_reset;
    dev_rst |=> data_oe == OE_NONE && !irq_oe
                && st.phase == PH_CTRL_HI;
  endproperty
  a_reset: assert property (p_reset) // [R12]
    else $error("device reset left port active");

endmodule
`default_nettype wire

// file: src/host_port_pkg.sv
`default_nettype none
package host_port_pkg;
  // ---------------------------------------------------------------
  // Widths and pin positions
  // ---------------------------------------------------------------
  localparam int DATA_W    = 8;
  localparam int ADDR_LO_W = 9;
  localparam int IDX_W     = 10;
  localparam int MEM_DEPTH = 1024;
  localparam int IRQ_SRC   = 4;
  localparam int CTRL_W    = 16;
  localparam int SYNC_W    = 24;
  // Positions inside the synchronised pin vector
  localparam int DATA_LSB    = 0;
  localparam int ADDR_LSB    = 8;
  localparam int ADDR_HI_BIT = 17;
  localparam int WR_BIT      = 18;
  localparam int RD_BIT      = 19;
  localparam int CS_BIT      = 20;
  localparam int STYLE_BIT   = 21;
  localparam int SEL_BIT     = 22;
  localparam int RST_BIT     = 23;
  // Serial mode roles of the data pins
  localparam int MISO_BIT = 0;
  localparam int MOSI_BIT = 1;
  localparam int SCLK_BIT = 2;
  localparam int SWAP_BIT = 5;
  localparam int CPHA_BIT = 6;
  localparam int CPOL_BIT = 7;
  // ---------------------------------------------------------------
  // Values and types
  // ---------------------------------------------------------------
  localparam logic [2:0]        CNT_LAST  = 3'h7;
  localparam logic [DATA_W-1:0] OE_ALL    = 8'hFF;
  localparam logic [DATA_W-1:0] OE_NONE   = 8'h00;
  localparam logic [DATA_W-1:0] MEM_RESET = 8'h00;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 24'h9C_0000;

  typedef enum logic [1:0] {
    PH_CTRL_HI = 2'b00,
    PH_CTRL_LO = 2'b01,
    PH_DATA    = 2'b10
  } spi_phase_t;

  typedef struct packed {
    logic [SYNC_W-1:0]  s1;
    logic [SYNC_W-1:0]  s2;
    logic [SYNC_W-1:0]  s3;
    spi_phase_t         phase;
    logic [2:0]         cnt;
    logic [CTRL_W-1:0]  shreg;
    logic               rd_op;
    logic               burst;
    logic [IDX_W-1:0]   addr;
    logic [DATA_W-1:0]  tx;
    logic [IRQ_SRC-1:0] pend;
    logic               irq;
    logic               irq_n;
    logic [DATA_W-1:0]  dout;
    logic [DATA_W-1:0]  doe;
  } state_t;

  localparam state_t ST_RESET = '{
    s1: SYNC_IDLE, s2: SYNC_IDLE, s3: SYNC_IDLE, phase: PH_CTRL_HI,
    cnt: 3'h0, shreg: 16'h0000, rd_op: 1'b0, burst: 1'b0,
    addr: 10'h000, tx: 8'h00, pend: 4'h0, irq: 1'b0, irq_n: 1'b1,
    dout: 8'h00, doe: 8'h00};
endpackage
`default_nettype wire

// file: verif/host_bus_model.sv
`default_nettype none
module host_bus_model (
  input  wire logic       clk,
  input  wire logic [7:0] data_out,
  input  wire logic [7:0] data_oe,
  input  wire logic [7:0] host_val,
  input  wire logic [7:0] host_en,
  output var  logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------
  // Data pins as the host sees them
  // ------------------------------------------
  logic [7:0] junk = 8'h55;
  // Released lines toggle so no stale value passes
  always @(negedge clk)
    junk <= ~junk;
  // Port-driven lines loop back; else host data where enabled, else junk
  always_comb
    for (int i = 0; i < 8; i++)
      data_in[i] = data_oe[i] ? data_out[i]
                 : (host_en[i] ? host_val[i] : junk[i]);
endmodule
`default_nettype wire

// file: verif/host_register_access_port_tb.sv
`default_nettype none
module host_register_access_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------
  // Stimulus, tasks and checks
  // ------------------------------------------
  logic       clk = 0, reset = 1, drst_n = 1, psel = 0, style = 0;
  logic       cs_n = 1, rd_n = 1, wr_n = 1, a12 = 0, gm = 0;
  logic       irq_n, irq_oe, cpol = 0, cpha = 0, swap = 0;
  logic [8:0] alo = '0;
  logic [7:0] dout, doe, din, hv = '0, he = '0;
  logic [3:0] ev = '0, msk = '0, ack = '0;
  int         fails = 0, comparisons = 0, cyc = 0;

  host_register_access_port DUT (.clk(clk), .reset(reset),
    .device_reset_n(drst_n), .port_select(psel),
    .bus_style_select(style), .host_select_n(cs_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .addr_hi(a12),
    .addr_lo(alo), .data_in(din), .data_out(dout), .data_oe(doe),
    .irq_event(ev), .irq_mask(msk), .irq_global_mask(gm),
    .irq_ack(ack), .irq_out_n(irq_n), .irq_oe(irq_oe));
  host_bus_model bus (.clk(clk), .data_out(dout), .data_oe(doe),
    .host_val(hv), .host_en(he), .data_in(din));

  initial
    forever #2 clk = ~clk;

  task automatic complete_run;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fails++;
      complete_run;
    end
  end

  task automatic cmp(input logic [7:0] got, exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask

  task automatic clk_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic par(input logic rd, c, a1, input logic [8:0] a,
                     input logic [7:0] d);
    @(negedge clk);
    a12 = a1;
    alo = a;
    hv = d;
    he = rd ? 8'h00 : 8'hFF;
    cs_n = c;
    wr_n = rd;
    rd_n = !style & !rd;
    clk_n(8);
    if (rd && !c)
    begin
      cmp(doe, 8'hFF, "drive");
      cmp(din, d, "read");
    end
    rd_n = 1;
    wr_n = style ? rd : 1'b1;
    clk_n(6);
    cs_n = 1;
    wr_n = 1;
    he = 0;
    clk_n(6);
    cmp(doe, 8'h00, "idle");
  endtask

  task automatic sbit(input logic b, output logic m);
    if (!cpha)
    begin
      hv[1] = b;
      #62.5 hv[2] = !cpol;
      m = din[0];
      #62.5 hv[2] = cpol;
    end
    else
    begin
      hv[2] = !cpol;
      hv[1] = b;
      #62.5 hv[2] = cpol;
      m = din[0];
      #62.5;
    end
  endtask

  task automatic spi(input logic rd, input logic [8:0] a, input int n,
                     input logic [15:0] d, input int cut);
    logic [13:0] f, r;
    logic [15:0] w;
    logic [7:0]  b, g;
    logic        m;
    f = {5'h1F, a};
    r = {<<{f}};
    w = {rd, swap ? f : r, n > 1};
    hv = {cpol, cpha, swap, 2'b00, cpol, 2'b00};
    he = 8'hFE;
    clk_n(4);
    cs_n = 0;
    // Keeps every following link edge off both clock edges
    #0.25;
    for (int i = 0; i < cut; i++)
      sbit(w[15 - i], m);
    if (cut == 16)
      for (int k = 0; k < n; k++)
      begin
        b = d[8 * k +: 8];
        for (int i = 0; i < 8; i++)
        begin
          sbit(swap ? b[7 - i] : b[i], m);
          g[swap ? 7 - i : i] = m;
        end
        if (rd)
          cmp(g, b, "serial read");
      end
    #62.5 cs_n = 1;
    clk_n(6);
    cmp(doe, 8'h00, "serial idle");
  endtask

  task automatic irq(input logic [3:0] e, a, input logic [7:0] x,
                     input string what);
    ev = e;
    ack = a;
    clk_n(1);
    ev = 0;
    ack = 0;
    clk_n(2);
    cmp({6'b0, irq_oe, irq_n}, x, what);
  endtask

  initial
  begin
    clk_n(20);
    reset = 0;
    clk_n(2);
    cmp({6'b0, irq_oe, irq_n}, 8'h01, "reset irq");
    cmp(doe, 8'h00, "reset bus");
    repeat (2)
    begin
      par(0, 0, 1, 9'h010 + style, 8'hA5 + style);
      par(0, 0, 0, 9'h010 + style, 8'h3C + style);
      par(0, 1, 1, 9'h010 + style, 8'hFF);
      par(1, 0, 1, 9'h010 + style, 8'hA5 + style);
      par(1, 0, 0, 9'h010 + style, 8'h3C + style);
      style = !style;
    end
    $display("test parallel done");
    psel = 1;
    for (int i = 0; i < 4; i++)
    begin
      {cpol, cpha} = 2'(i);
      swap = cpol;
      spi(0, {7'h08, cpol, cpha}, 1, {10'h016, cpol, cpha}, 16);
      spi(1, {7'h08, cpol, cpha}, 1, {10'h016, cpol, cpha}, 16);
    end
    spi(0, 9'h000, 1, 16'h0000, 5);
    spi(1, 9'h010, 2, 16'hA6A5, 16);
    $display("test serial done");
    psel = 0;
    irq(4'h2, 4'h0, 8'h02, "raise");
    irq(4'h0, 4'h2, 8'h01, "ack");
    msk = 4'h4;
    irq(4'h4, 4'h0, 8'h01, "masked");
    msk = 0;
    irq(4'h0, 4'h0, 8'h02, "unmasked");
    gm = 1;
    irq(4'h0, 4'h0, 8'h01, "global");
    gm = 0;
    irq(4'h0, 4'h4, 8'h01, "cleared");
    $display("test interrupt done");
    irq(4'h1, 4'h0, 8'h02, "pre reset");
    drst_n = 0;
    clk_n(8);
    drst_n = 1;
    clk_n(6);
    cmp({6'b0, irq_oe, irq_n}, 8'h01, "reset irq clear");
    par(1, 0, 1, 9'h010, 8'h00);
    $display("test device reset done");
    complete_run;
  end
endmodule
`default_nettype wire
